// [verilog/tac_alarm.sv]
// Thermal alarm: config register, fault queue and open-drain alarm pin
// Notes on behaviour
// - One 8-bit control register for alarm setup
// - Queue code 00/01/10/11 needs 1/2/4/6 faults
// - Faults must be consecutive; good result restarts
// - Level bit zero asserts low, one high
// - Alarm pin only pulls low or releases
// - Mode bit zero comparator, one interrupt
// - Comparator clears below clear threshold, holds between
// - Interrupt asserts on rise above or fall below
// - Interrupt alarm holds until a read
// - Shutdown bit stops measurement
// - Serial slave stays alive during shutdown
// - Registers still read and write in shutdown
// - Read of any register clears interrupt alarm
// - Interrupt events alternate high then low side
// - Entering shutdown clears interrupt alarm
// - Values are 9-bit signed, half-degree steps
`timescale 1ns/10ps
`default_nettype none
module tac_alarm
    import tac_pkg::*;
(
    // System
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Register port from serial slave
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [1:0] reg_addr,
    input  wire logic [8:0] reg_wdata,
    output var  logic [8:0] reg_rdata,
    // Converter side, on its own clock
    input  wire logic       conv_clk,
    input  wire logic       conv_done,
    input  wire logic [8:0] conv_temp,
    output var  logic       conv_enable,
    // Alarm pin, open drain
    input  wire logic       alarm_pin_in,
    output var  logic       over_temp_alarm_output,
    output var  logic       over_temp_alarm_oe,
    // Status
    output var  logic       alarm_active
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] fault_target(input logic [1:0] code);
        case (code)
            2'h0:    fault_target = TAC_FAULTS_Q0;
            2'h1:    fault_target = TAC_FAULTS_Q1;
            2'h2:    fault_target = TAC_FAULTS_Q2;
            default: fault_target = TAC_FAULTS_Q3;
        endcase
    endfunction : fault_target

    function automatic logic signed_gt(input logic [8:0] a, input logic [8:0] b);
        signed_gt = $signed(a) > $signed(b);
    endfunction : signed_gt

    // Saturating, so a long fault run cannot wrap back to zero
    function automatic logic [2:0] sat_step(input logic [2:0] cnt, input logic [2:0] top);
        sat_step = (cnt >= top) ? top : cnt + 3'h1;
    endfunction : sat_step

    ////////////////////////////////////////////////////////////////////////
    // Converter domain: capture word and toggle per conversion
    logic [8:0] cd_temp_r;
    logic [8:0] cd_temp_nxt;
    logic       cd_tog_r;
    logic       cd_tog_nxt;
    logic       cd_run_m_r;
    logic       cd_run_r;

    always_comb begin
        cd_temp_nxt = cd_temp_r;
        cd_tog_nxt  = cd_tog_r;
        if (conv_done && cd_run_r) begin
            cd_temp_nxt = conv_temp;
            cd_tog_nxt  = ~cd_tog_r;
        end
    end

    always_ff @(posedge conv_clk or negedge reset_n) begin
        if (!reset_n) begin
            cd_temp_r  <= 9'h000;
            cd_tog_r   <= 1'b0;
            cd_run_m_r <= 1'b0;
            cd_run_r   <= 1'b0;
        end else begin
            cd_temp_r  <= cd_temp_nxt;
            cd_tog_r   <= cd_tog_nxt;
            cd_run_m_r <= conv_enable;
            cd_run_r   <= cd_run_m_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main domain
    logic [7:0] config_r;
    logic [7:0] config_nxt;
    logic [8:0] set_thresh_r;
    logic [8:0] set_thresh_nxt;
    logic [8:0] clear_thresh_r;
    logic [8:0] clear_thresh_nxt;
    logic [8:0] temp_r;
    logic [8:0] temp_nxt;
    logic       tog_m_r;
    logic       tog_s_r;
    logic       tog_d_r;
    logic       pin_m_r;
    logic       pin_s_r;
    logic [2:0] hi_cnt_r;
    logic [2:0] hi_cnt_nxt;
    logic [2:0] lo_cnt_r;
    logic [2:0] lo_cnt_nxt;
    logic       asserted_r;
    logic       asserted_nxt;
    tac_arm_e   arm_r;
    tac_arm_e   arm_nxt;
    logic [8:0] rdata_nxt;
    logic       drive_low_nxt;

    logic       new_result;
    logic       shutdown;
    logic       int_mode;
    logic       hi_trip;
    logic       lo_trip;
    logic [2:0] target;

    assign shutdown = config_r[TAC_CFG_SHUTDOWN_BIT];
    assign int_mode = config_r[TAC_CFG_INTMODE_BIT];
    // Toggle crossing: temp word is stable long before the toggle lands
    assign new_result = (tog_s_r ^ tog_d_r) && !shutdown;
    assign target = fault_target(config_r[TAC_CFG_QUEUE_MSB:TAC_CFG_QUEUE_LSB]);

    ////////////////////////////////////////////////////////////////////////
    // Register group: setup, thresholds and read port
    always_comb begin
        config_nxt       = config_r;
        set_thresh_nxt   = set_thresh_r;
        clear_thresh_nxt = clear_thresh_r;
        rdata_nxt        = 9'h000;

        // Writes stay live in shutdown; the temperature offset is read only
        if (reg_wr) begin
            case (reg_addr)
                TAC_OFS_CONFIG:       config_nxt = reg_wdata[7:0] & TAC_CFG_WRITE_MASK;
                TAC_OFS_CLEAR_THRESH: clear_thresh_nxt = reg_wdata;
                TAC_OFS_SET_THRESH:   set_thresh_nxt = reg_wdata;
                default:              ;
            endcase
        end

        // Read data shows the old contents during a same-cycle write
        case (reg_addr)
            TAC_OFS_TEMP:         rdata_nxt = temp_r;
            TAC_OFS_CONFIG:       rdata_nxt = {1'b0, config_r};
            TAC_OFS_CLEAR_THRESH: rdata_nxt = clear_thresh_r;
            default:              rdata_nxt = set_thresh_r;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            config_r       <= TAC_CONFIG_RESET;
            set_thresh_r   <= TAC_SET_THRESH_RESET;
            clear_thresh_r <= TAC_CLEAR_THRESH_RESET;
            reg_rdata      <= 9'h000;
        end else begin
            config_r       <= config_nxt;
            set_thresh_r   <= set_thresh_nxt;
            clear_thresh_r <= clear_thresh_nxt;
            reg_rdata      <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: only the toggle's second and third stages are read by logic
    // Pin readback is only watched, it feeds no decision
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tog_m_r <= 1'b0;
            tog_s_r <= 1'b0;
            tog_d_r <= 1'b0;
            pin_m_r <= 1'b1;
            pin_s_r <= 1'b1;
        end else begin
            tog_m_r <= cd_tog_r;
            tog_s_r <= tog_m_r;
            tog_d_r <= tog_s_r;
            pin_m_r <= alarm_pin_in;
            pin_s_r <= pin_m_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Queue group: one evaluation per conversion, counts saturate at target
    always_comb begin
        temp_nxt   = temp_r;
        hi_cnt_nxt = hi_cnt_r;
        lo_cnt_nxt = lo_cnt_r;
        hi_trip    = 1'b0;
        lo_trip    = 1'b0;

        if (new_result) begin
            temp_nxt = cd_temp_r;
            // Any good result on a side restarts that side's count
            if (signed_gt(cd_temp_r, set_thresh_r)) begin
                hi_cnt_nxt = sat_step(hi_cnt_r, target);
            end else begin
                hi_cnt_nxt = 3'h0;
            end
            if (signed_gt(clear_thresh_r, cd_temp_r)) begin
                lo_cnt_nxt = sat_step(lo_cnt_r, target);
            end else begin
                lo_cnt_nxt = 3'h0;
            end
            hi_trip = (hi_cnt_nxt >= target);
            lo_trip = (lo_cnt_nxt >= target);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_r   <= 9'h000;
            hi_cnt_r <= 3'h0;
            lo_cnt_r <= 3'h0;
        end else begin
            temp_r   <= temp_nxt;
            hi_cnt_r <= hi_cnt_nxt;
            lo_cnt_r <= lo_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm group: logical alarm state and interrupt arming side
    always_comb begin
        asserted_nxt = asserted_r;
        arm_nxt      = arm_r;

        if (!int_mode) begin
            // Between the thresholds the comparator holds its state
            arm_nxt = TAC_ARM_HIGH;
            if (hi_trip) begin
                asserted_nxt = 1'b1;
            end else if (lo_trip) begin
                asserted_nxt = 1'b0;
            end
        end else begin
            // Read clears first, so a same-cycle event still sets
            if (reg_rd) begin
                asserted_nxt = 1'b0;
            end
            if ((!asserted_r || reg_rd) && arm_r == TAC_ARM_HIGH && hi_trip) begin
                asserted_nxt = 1'b1;
                arm_nxt      = TAC_ARM_LOW;
            end else if ((!asserted_r || reg_rd) && arm_r == TAC_ARM_LOW && lo_trip) begin
                asserted_nxt = 1'b1;
                arm_nxt      = TAC_ARM_HIGH;
            end
            // Shutdown entry overrides all, results are frozen from then on
            if (config_nxt[TAC_CFG_SHUTDOWN_BIT] && !shutdown) begin
                asserted_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            asserted_r <= 1'b0;
            arm_r      <= TAC_ARM_HIGH;
        end else begin
            asserted_r <= asserted_nxt;
            arm_r      <= arm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output group: pins and status leave straight from flip-flops
    always_comb begin
        // Pull low when the asserted level is low, else while idle
        drive_low_nxt = config_r[TAC_CFG_LEVEL_BIT] ? !asserted_nxt : asserted_nxt;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_enable            <= 1'b1;
            over_temp_alarm_output <= 1'b0;
            over_temp_alarm_oe     <= 1'b0;
            alarm_active           <= 1'b0;
        end else begin
            conv_enable            <= !config_nxt[TAC_CFG_SHUTDOWN_BIT];
            // No high drive at all; the pull-up makes the high level
            over_temp_alarm_output <= 1'b0;
            over_temp_alarm_oe     <= drive_low_nxt;
            alarm_active           <= asserted_nxt;
        end
    end

endmodule : tac_alarm
`default_nettype wire

// [verilog/tac_pkg.sv]
// Constants for the thermal alarm output control block
package tac_pkg;
    // Register offsets
    localparam logic [1:0] TAC_OFS_TEMP          = 2'h0;
    localparam logic [1:0] TAC_OFS_CONFIG        = 2'h1;
    localparam logic [1:0] TAC_OFS_CLEAR_THRESH  = 2'h2;
    localparam logic [1:0] TAC_OFS_SET_THRESH    = 2'h3;
    // Config field positions
    localparam int TAC_CFG_SHUTDOWN_BIT = 0;
    localparam int TAC_CFG_INTMODE_BIT  = 1;
    localparam int TAC_CFG_LEVEL_BIT    = 2;
    localparam int TAC_CFG_QUEUE_LSB    = 3;
    localparam int TAC_CFG_QUEUE_MSB    = 4;
    localparam logic [7:0] TAC_CFG_WRITE_MASK = 8'h1F;
    // Reset values
    localparam logic [7:0] TAC_CONFIG_RESET       = 8'h00;
    localparam logic [8:0] TAC_CLEAR_THRESH_RESET = 9'h096;
    localparam logic [8:0] TAC_SET_THRESH_RESET   = 9'h0A0;
    // Fault counts per queue code
    localparam logic [2:0] TAC_FAULTS_Q0 = 3'h1;
    localparam logic [2:0] TAC_FAULTS_Q1 = 3'h2;
    localparam logic [2:0] TAC_FAULTS_Q2 = 3'h4;
    localparam logic [2:0] TAC_FAULTS_Q3 = 3'h6;

    typedef enum logic [0:0] {
        TAC_ARM_HIGH = 1'b0,
        TAC_ARM_LOW  = 1'b1
    } tac_arm_e;
endpackage : tac_pkg

// [testbench/tac_alarm_asserts.sv]
// Port-level assertions for the thermal alarm block
`timescale 1ns/10ps
`default_nettype none
module tac_alarm_asserts
    import tac_pkg::*;
(
    // System
    input wire logic       clk,
    input wire logic       reset_n,
    // Register port
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [1:0] reg_addr,
    input wire logic [8:0] reg_wdata,
    input wire logic [8:0] reg_rdata,
    // Alarm and measurement
    input wire logic       conv_enable,
    input wire logic       over_temp_alarm_output,
    input wire logic       over_temp_alarm_oe,
    input wire logic       alarm_active
);
    wire logic  cfg_w = reg_wr && reg_addr == TAC_OFS_CONFIG;
    logic [7:0] cfg_r;
    logic [8:0] clr_r;
    logic [3:0] age_r;
    // Shadow of the written setup; age lets crossings settle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r <= TAC_CONFIG_RESET;
            clr_r <= TAC_CLEAR_THRESH_RESET;
            age_r <= 4'h0;
        end else begin
            if (cfg_w) cfg_r <= reg_wdata[7:0] & TAC_CFG_WRITE_MASK;
            if (reg_wr && reg_addr == TAC_OFS_CLEAR_THRESH) clr_r <= reg_wdata;
            age_r <= cfg_w ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_shut_entry;
        cfg_w && reg_wdata[0] && reg_wdata[1] && !cfg_r[0] && cfg_r[1];
    endsequence
    sequence s_read_late;
        $past(reg_rd) || $past(reg_rd, 2) || $past(reg_rd, 3);
    endsequence
    property p_od_low; over_temp_alarm_output == 1'b0; endproperty
    property p_pol; age_r > 4'h1 |-> over_temp_alarm_oe == (alarm_active ^ cfg_r[2]); endproperty
    property p_int_hold; cfg_r[1] && age_r > 4'h3 && $fell(alarm_active) |-> s_read_late; endproperty
    property p_rd_cfg; reg_addr == TAC_OFS_CONFIG |=> reg_rdata == {1'b0, $past(cfg_r)}; endproperty
    property p_rd_clr; reg_addr == TAC_OFS_CLEAR_THRESH |=> reg_rdata == $past(clr_r); endproperty
    property p_conv_en; age_r == 4'hF |-> conv_enable == !cfg_r[0]; endproperty
    property p_shut_clr; s_shut_entry |-> ##[1:3] !alarm_active; endproperty
    property p_freeze; age_r == 4'hF && cfg_r[0] |=> $stable(alarm_active); endproperty
    a_od_low: assert property (p_od_low) else $error("alarm pin driven high");
    a_pol: assert property (p_pol) else $error("alarm level wrong");
    a_int_hold: assert property (p_int_hold) else $error("alarm dropped without read");
    a_rd_cfg: assert property (p_rd_cfg) else $error("setup readback wrong");
    a_rd_clr: assert property (p_rd_clr) else $error("threshold readback wrong");
    a_conv_en: assert property (p_conv_en) else $error("measure enable wrong");
    a_shut_clr: assert property (p_shut_clr) else $error("shutdown kept alarm");
    a_freeze: assert property (p_freeze) else $error("alarm moved in shutdown");
endmodule : tac_alarm_asserts
bind tac_alarm tac_alarm_asserts u_asserts (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_enable(conv_enable),
    .over_temp_alarm_output(over_temp_alarm_output), .over_temp_alarm_oe(over_temp_alarm_oe),
    .alarm_active(alarm_active));
`default_nettype wire

// [testbench/tac_conv_model.sv]
// Converter and pull-up model facing the alarm block
`timescale 1ns/10ps
`default_nettype none
module tac_conv_model (
    // Converter side
    input  wire logic       conv_clk,
    output var  logic       conv_done,
    output var  logic [8:0] conv_temp,
    // Alarm pin
    input  wire logic       over_temp_alarm_oe,
    output wire logic       alarm_pin_in
);
    // Released pin floats up through the resistor
    assign alarm_pin_in = !over_temp_alarm_oe;
    initial begin
        conv_done = 1'b0;
        conv_temp = 9'h000;
    end
    // Stale result is inverted so nothing relies on it
    task automatic send(input logic [8:0] t);
        @(posedge conv_clk) #1;
        conv_done = 1'b1;
        conv_temp = t;
        @(posedge conv_clk) #1;
        conv_done = 1'b0;
        conv_temp = ~t;
        repeat (8) @(posedge conv_clk);
    endtask : send
endmodule : tac_conv_model
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the thermal alarm block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import tac_pkg::*;
    logic             clk = 1'b0, conv_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0]       reg_addr = 2'h0;
    logic [8:0]       reg_wdata = 9'h000;
    wire  logic [8:0] reg_rdata, conv_temp;
    wire  logic       conv_done, conv_enable, pin, alm_out, oe, active;
    int               errors = 0, n_checks = 0, n;
    localparam logic [8:0] HOT = 9'h0B0, MID = 9'h09A, COLD = 9'h1F0;
    // Rows: address, written value, read-back value
    logic [19:0] rows [5] = '{{2'h1, 9'h01F, 9'h01F}, {2'h1, 9'h000, 9'h000}, {2'h2, 9'h1F0, 9'h1F0},
                              {2'h2, 9'h096, 9'h096}, {2'h3, 9'h0A0, 9'h0A0}};
    initial forever #2.5 clk = ~clk;
    initial begin
        #3.1;
        forever #6 conv_clk = ~conv_clk;
    end
    tac_alarm dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_clk(conv_clk), .conv_done(conv_done),
        .conv_temp(conv_temp), .conv_enable(conv_enable), .alarm_pin_in(pin),
        .over_temp_alarm_output(alm_out), .over_temp_alarm_oe(oe), .alarm_active(active));
    tac_conv_model u_conv (.conv_clk(conv_clk), .conv_done(conv_done), .conv_temp(conv_temp),
        .over_temp_alarm_oe(oe), .alarm_pin_in(pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [8:0] d);
        @(posedge clk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk) #1;
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [8:0] e);
        @(posedge clk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk) #1;
        reg_rd = 1'b0;
        @(posedge clk) #1;
        chk(reg_rdata, e);
    endtask : rd
    task automatic give_verdict;
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        errors++;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge clk);
        chk(9'(alm_out), 9'h000);
        chk(9'(oe), 9'h000);
        #1 reset_n = 1'b1;
        rd(TAC_OFS_CONFIG, TAC_CONFIG_RESET);
        rd(TAC_OFS_CLEAR_THRESH, TAC_CLEAR_THRESH_RESET);
        chk(9'(conv_enable), 9'h001);
        foreach (rows[i]) begin
            wr(rows[i][19:18], rows[i][17:9]);
            rd(rows[i][19:18], rows[i][8:0]);
        end
        // Every queue code, a restart on each side
        for (int q = 0; q < 4; q++) begin
            n = (q == 3) ? 6 : (1 << q);
            wr(TAC_OFS_CONFIG, 9'(q << 3));
            repeat (n - 1) u_conv.send(HOT);
            u_conv.send(MID);
            repeat (n - 1) u_conv.send(HOT);
            chk(9'(active), 9'h000);
            u_conv.send(HOT);
            chk(9'(active), 9'h001);
            repeat (n - 1) u_conv.send(COLD);
            u_conv.send(MID);
            chk(9'(oe), 9'h001);
            repeat (n) u_conv.send(COLD);
            chk(9'(active), 9'h000);
        end
        // Temperature offset is read only and keeps the last result
        wr(TAC_OFS_TEMP, HOT);
        rd(TAC_OFS_TEMP, COLD);
        wr(TAC_OFS_CONFIG, 9'h004);
        repeat (2) @(posedge clk) #1;
        chk(9'(pin), 9'h000);
        chk(9'(alm_out), 9'h000);
        // Count must survive a shutdown untouched
        wr(TAC_OFS_CONFIG, 9'h010);
        repeat (2) u_conv.send(HOT);
        wr(TAC_OFS_CONFIG, 9'h011);
        repeat (20) @(posedge clk);
        repeat (2) u_conv.send(HOT);
        rd(TAC_OFS_CONFIG, 9'h011);
        chk(9'(conv_enable), 9'h000);
        wr(TAC_OFS_CONFIG, 9'h010);
        repeat (20) @(posedge clk);
        u_conv.send(HOT);
        chk(9'(active), 9'h000);
        u_conv.send(HOT);
        chk(9'(active), 9'h001);
        // Second reset, then interrupt behaviour
        @(posedge clk) #1 reset_n = 1'b0;
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        wr(TAC_OFS_CONFIG, 9'h002);
        u_conv.send(HOT);
        chk(9'(active), 9'h001);
        u_conv.send(MID);
        chk(9'(active), 9'h001);
        rd(TAC_OFS_CLEAR_THRESH, TAC_CLEAR_THRESH_RESET);
        chk(9'(active), 9'h000);
        u_conv.send(HOT);
        chk(9'(active), 9'h000);
        u_conv.send(COLD);
        chk(9'(active), 9'h001);
        rd(TAC_OFS_CONFIG, 9'h002);
        u_conv.send(HOT);
        chk(9'(active), 9'h001);
        wr(TAC_OFS_CONFIG, 9'h003);
        repeat (4) @(posedge clk);
        chk(9'(active), 9'h000);
        give_verdict;
    end
endmodule : tb_top
`default_nettype wire
